// file: logic/mmt_cmp_if.sv
// comparator connection bundle
`timescale 1ns/1ps
interface mmt_cmp_if;
   logic              running;
   logic              reload;
   logic              disarm;
   mmt_pkg::mmt_word_t count;
   mmt_pkg::mmt_word_t value;
   logic              hit;
   modport ctrl (output running, output reload, output disarm, output count, output value,
                 input hit);
   modport cmp  (input running, input reload, input disarm, input count, input value,
                 output hit);
endinterface

// file: logic/mmt_comparator.sv
// one-shot compare unit
`timescale 1ns/1ps
`include "mmt_defs.svh"
module mmt_comparator #(
   parameter mmt_pkg::mmt_cmp_kind_t KIND = mmt_pkg::MMT_CMP_EQ
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   mmt_cmp_if.cmp    bus
);
   logic armed_r;
   logic hit_r;
   logic match;

   assign match = (KIND == mmt_pkg::MMT_CMP_MAG) ? (bus.count >= bus.value)
                                                 : (bus.count == bus.value);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         armed_r <= 1'b0;
      end else if (bus.reload) begin
         armed_r <= 1'b1;
      // stays armed while stopped so compares can be loaded before the start
      end else if (bus.disarm || hit_r) begin
         armed_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hit_r <= 1'b0;
      end else begin
         hit_r <= armed_r && bus.running && match && !bus.reload && !bus.disarm && !hit_r;
      end
   end
   assign bus.hit = hit_r;

   AST_ONE_SHOT: assert property (@(posedge mclk) disable iff (!rst_n)
      hit_r && !bus.reload |=> !hit_r) else $error("comparator fired twice");
endmodule // mmt_comparator

// file: logic/mmt_defs.svh
// constants for the motor mode timer unit
`ifndef MMT_DEFS_SVH
`define MMT_DEFS_SVH
// register indexes (word indexes; the apb byte address is the index times four)
`define MMT_IDX_CTRL_A     16'h1fa4
`define MMT_IDX_CTRL_B     16'h1fa5
`define MMT_IDX_CAPTURE    16'h1fa6
`define MMT_IDX_CMP_ONE    16'h1fa8
`define MMT_IDX_CMP_TWO    16'h1faa
`define MMT_IDX_CMP_THREE  16'h1fac
// control a fields
`define MMT_A_RUN          0
`define MMT_A_CLR_POS      1
`define MMT_A_SOFT_CLR     2
`define MMT_A_CLR_OVL      3
`define MMT_A_CLR_M3       4
`define MMT_A_SEL_LO       5
// control b fields
`define MMT_B_CAP_POS      1
`define MMT_B_SOFT_CAP     2
`define MMT_B_CAP_OVL      3
`define MMT_B_OVF          5
`define MMT_B_DBG          7
// clock select codes
`define MMT_SEL_DIV8       3'b000
`define MMT_SEL_DIV16      3'b010
`define MMT_SEL_DIV32      3'b100
`define MMT_SEL_DIV64      3'b110
`define MMT_SEL_DIV128     3'b001
`define MMT_COUNT_MAX      16'hffff
`define MMT_RESET_CTRL     8'h00
`define MMT_RESET_WORD     16'h0000
`endif

// file: logic/mmt_pkg.sv
// types for the motor mode timer unit
package mmt_pkg;
   typedef enum logic [1:0] {MMT_CMP_MAG, MMT_CMP_EQ} mmt_cmp_kind_t;
   typedef logic [15:0] mmt_word_t;
endpackage

// file: logic/mmt_timer_unit.sv
// motor mode timer unit with apb register access
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "mmt_defs.svh"
//------------------------------------------------------------
//------------------------------------------------------------
module mmt_timer_unit (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        position_detect_irq,
   input  wire logic        overload_trip,
   output logic             irq_timer_one,
   output logic             irq_timer_two,
   output logic             irq_timer_three,
   output logic             debug_pin
);
   //------------------------------------------------------------
   // reset release
   //------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   //------------------------------------------------------------
   // apb decode
   //------------------------------------------------------------
   function automatic logic hit_idx(input logic [31:0] a, input logic [15:0] idx);
      hit_idx = (a == {14'h0000, idx, 2'b00});
   endfunction

   logic wr_en;
   logic rd_en;
   logic mapped;
   assign wr_en  = psel && penable && pwrite && pready;
   assign rd_en  = psel && !penable && !pwrite;
   assign mapped = hit_idx(paddr, `MMT_IDX_CTRL_A) || hit_idx(paddr, `MMT_IDX_CTRL_B)
                || hit_idx(paddr, `MMT_IDX_CAPTURE) || hit_idx(paddr, `MMT_IDX_CMP_ONE)
                || hit_idx(paddr, `MMT_IDX_CMP_TWO) || hit_idx(paddr, `MMT_IDX_CMP_THREE);

   logic wr_a;
   logic wr_b;
   logic wr_c1;
   logic wr_c2;
   logic wr_c3;
   assign wr_a  = wr_en && hit_idx(paddr, `MMT_IDX_CTRL_A);
   assign wr_b  = wr_en && hit_idx(paddr, `MMT_IDX_CTRL_B);
   assign wr_c1 = wr_en && hit_idx(paddr, `MMT_IDX_CMP_ONE);
   assign wr_c2 = wr_en && hit_idx(paddr, `MMT_IDX_CMP_TWO);
   assign wr_c3 = wr_en && hit_idx(paddr, `MMT_IDX_CMP_THREE);

   // no wait state: pready rises in the first access cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   //------------------------------------------------------------
   // control registers
   //------------------------------------------------------------
   logic [2:0] count_clock_sel;
   logic       clear_on_third_match_en;
   logic       clear_on_overload_en;
   logic       clear_on_position_en;
   logic       count_run_en;
   logic       debug_irq_out_en;
   logic       capture_on_overload_en;
   logic       capture_on_position_en;
   logic       soft_clear_cmd;
   logic       soft_capture_cmd;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_clock_sel         <= 3'h0;
         clear_on_third_match_en <= 1'b0;
         clear_on_overload_en    <= 1'b0;
         clear_on_position_en    <= 1'b0;
         count_run_en            <= 1'b0;
      end else if (wr_a) begin
         count_clock_sel         <= pwdata[`MMT_A_SEL_LO +: 3];
         clear_on_third_match_en <= pwdata[`MMT_A_CLR_M3];
         clear_on_overload_en    <= pwdata[`MMT_A_CLR_OVL];
         clear_on_position_en    <= pwdata[`MMT_A_CLR_POS];
         count_run_en            <= pwdata[`MMT_A_RUN];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         debug_irq_out_en       <= 1'b0;
         capture_on_overload_en <= 1'b0;
         capture_on_position_en <= 1'b0;
      end else if (wr_b) begin
         debug_irq_out_en       <= pwdata[`MMT_B_DBG];
         capture_on_overload_en <= pwdata[`MMT_B_CAP_OVL];
         capture_on_position_en <= pwdata[`MMT_B_CAP_POS];
      end
   end

   // write-only command bits act as pulses
   assign soft_clear_cmd   = wr_a && pwdata[`MMT_A_SOFT_CLR];
   assign soft_capture_cmd = wr_b && pwdata[`MMT_B_SOFT_CAP];

   //------------------------------------------------------------
   // prescaler
   //------------------------------------------------------------
   logic [6:0] pre_r;
   logic       tick;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= 7'h00;
      end else if (!count_run_en) begin
         pre_r <= 7'h00;
      end else begin
         pre_r <= pre_r + 7'h01;
      end
   end

   always_comb begin
      case (count_clock_sel)
         `MMT_SEL_DIV8:   tick = (pre_r[2:0] == 3'h7);
         `MMT_SEL_DIV16:  tick = (pre_r[3:0] == 4'hf);
         `MMT_SEL_DIV32:  tick = (pre_r[4:0] == 5'h1f);
         `MMT_SEL_DIV64:  tick = (pre_r[5:0] == 6'h3f);
         `MMT_SEL_DIV128: tick = (pre_r == 7'h7f);
         default:         tick = 1'b0;
      endcase
   end

   //------------------------------------------------------------
   // mode timer
   //------------------------------------------------------------
   mmt_cmp_if c1 ();
   mmt_cmp_if c2 ();
   mmt_cmp_if c3 ();

   logic               clear_now;
   mmt_pkg::mmt_word_t count_r;
   logic               count_overflow_flag;

   assign clear_now = soft_clear_cmd
                   || (clear_on_position_en && position_detect_irq)
                   || (clear_on_overload_en && overload_trip)
                   || (clear_on_third_match_en && c3.hit);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= `MMT_RESET_WORD;
      end else if (clear_now) begin
         count_r <= `MMT_RESET_WORD;
      end else if (count_run_en && tick && count_r != `MMT_COUNT_MAX) begin
         count_r <= count_r + 16'h0001;
      end
   end

   // overflow stays set until the timer is cleared in a cycle without a full-scale tick
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_overflow_flag <= 1'b0;
      end else if (count_run_en && tick && count_r == `MMT_COUNT_MAX) begin
         count_overflow_flag <= 1'b1;
      end else if (clear_now) begin
         count_overflow_flag <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // capture
   //------------------------------------------------------------
   mmt_pkg::mmt_word_t interval_capture;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         interval_capture <= `MMT_RESET_WORD;
      end else if (soft_capture_cmd
                || (capture_on_position_en && position_detect_irq)
                || (capture_on_overload_en && overload_trip)) begin
         interval_capture <= count_r;
      end
   end

   //------------------------------------------------------------
   // comparators
   //------------------------------------------------------------
   mmt_pkg::mmt_word_t magnitude_compare_one;
   mmt_pkg::mmt_word_t match_compare_two;
   mmt_pkg::mmt_word_t match_compare_three;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         magnitude_compare_one <= `MMT_RESET_WORD;
         match_compare_two     <= `MMT_RESET_WORD;
         match_compare_three   <= `MMT_RESET_WORD;
      end else begin
         if (wr_c1) magnitude_compare_one <= pwdata[15:0];
         if (wr_c2) match_compare_two <= pwdata[15:0];
         if (wr_c3) match_compare_three <= pwdata[15:0];
      end
   end

   // dropping the run bit cancels every armed compare
   logic stop_now;
   assign stop_now   = wr_a && count_run_en && !pwdata[`MMT_A_RUN];
   assign c1.running = count_run_en;
   assign c2.running = count_run_en;
   assign c3.running = count_run_en;
   assign c1.disarm  = clear_now || stop_now;
   assign c2.disarm  = clear_now || stop_now;
   assign c3.disarm  = clear_now || stop_now;
   assign c1.reload  = wr_c1;
   assign c2.reload  = wr_c2;
   assign c3.reload  = wr_c3;
   assign c1.count   = count_r;
   assign c2.count   = count_r;
   assign c3.count   = count_r;
   assign c1.value   = magnitude_compare_one;
   assign c2.value   = match_compare_two;
   assign c3.value   = match_compare_three;

   mmt_comparator #(.KIND(mmt_pkg::MMT_CMP_MAG)) u_magnitude_compare_one (.mclk(mclk), .rst_n(rst_n), .bus(c1));
   mmt_comparator #(.KIND(mmt_pkg::MMT_CMP_EQ))  u_match_compare_two (.mclk(mclk), .rst_n(rst_n), .bus(c2));
   mmt_comparator #(.KIND(mmt_pkg::MMT_CMP_EQ))  u_match_compare_three (.mclk(mclk), .rst_n(rst_n), .bus(c3));

   //------------------------------------------------------------
   // outputs
   //------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_timer_one   <= 1'b0;
         irq_timer_two   <= 1'b0;
         irq_timer_three <= 1'b0;
         debug_pin       <= 1'b0;
      end else begin
         irq_timer_one   <= c1.hit;
         irq_timer_two   <= c2.hit;
         irq_timer_three <= c3.hit;
         debug_pin       <= debug_irq_out_en && (c1.hit || c2.hit || c3.hit);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         if (hit_idx(paddr, `MMT_IDX_CTRL_A)) begin
            prdata <= {24'h00_0000, count_clock_sel, clear_on_third_match_en,
                       clear_on_overload_en, 1'b0, clear_on_position_en, count_run_en};
         end else if (hit_idx(paddr, `MMT_IDX_CTRL_B)) begin
            prdata <= {24'h00_0000, debug_irq_out_en, 1'b0, count_overflow_flag, 1'b0,
                       capture_on_overload_en, 1'b0, capture_on_position_en, 1'b0};
         end else if (hit_idx(paddr, `MMT_IDX_CAPTURE)) begin
            prdata <= {16'h0000, interval_capture};
         end else if (hit_idx(paddr, `MMT_IDX_CMP_ONE)) begin
            prdata <= {16'h0000, magnitude_compare_one};
         end else if (hit_idx(paddr, `MMT_IDX_CMP_TWO)) begin
            prdata <= {16'h0000, match_compare_two};
         end else if (hit_idx(paddr, `MMT_IDX_CMP_THREE)) begin
            prdata <= {16'h0000, match_compare_three};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   AST_SATURATE: assert property (@(posedge mclk) disable iff (!rst_n)
      count_r == `MMT_COUNT_MAX && !clear_now |=> count_r == `MMT_COUNT_MAX)
      else $error("timer wrapped past full scale");
   AST_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
      clear_now |=> count_r == `MMT_RESET_WORD) else $error("timer not cleared");
   AST_SOFT_CAP: assert property (@(posedge mclk) disable iff (!rst_n)
      soft_capture_cmd |=> interval_capture == $past(count_r)) else $error("capture missed");
   AST_POS_CAP: assert property (@(posedge mclk) disable iff (!rst_n)
      capture_on_position_en && position_detect_irq |=> interval_capture == $past(count_r))
      else $error("position capture missed");
   AST_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      !count_run_en && !clear_now |=> $stable(count_r)) else $error("count moved while off");
   AST_IRQ_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_timer_two |=> !irq_timer_two) else $error("interrupt longer than one cycle");
   AST_DISARM: assert property (@(posedge mclk) disable iff (!rst_n)
      !count_run_en && !c1.hit |=> !c1.hit) else $error("comparator fired while stopped");
   AST_MAG: assert property (@(posedge mclk) disable iff (!rst_n)
      c1.hit |-> $past(count_r) >= $past(magnitude_compare_one))
      else $error("timer one fired below compare");
   AST_OVF: assert property (@(posedge mclk) disable iff (!rst_n)
      count_run_en && tick && count_r == `MMT_COUNT_MAX |=> count_overflow_flag)
      else $error("overflow flag not set");
endmodule // mmt_timer_unit

// file: test/mmt_far_side.sv
// far-side model: position detect and overload trip sources
`timescale 1ns/1ps
module mmt_far_side (
   input  wire logic mclk,
   input  wire logic pos_req,
   input  wire logic ovl_req,
   output logic      position_detect_irq,
   output logic      overload_trip
);
   // each request is copied to its output one cycle later, as long as it is held
   always @(posedge mclk) begin
      position_detect_irq <= pos_req;
      overload_trip       <= ovl_req;
   end
   initial begin
      position_detect_irq = 1'b0;
      overload_trip       = 1'b0;
   end
endmodule // mmt_far_side

// file: test/mmt_timer_unit_tb_top.sv
// self-checking bench for the motor mode timer unit
`timescale 1ns/1ps
`include "mmt_defs.svh"
module mmt_timer_unit_tb_top;
   localparam logic [15:0] RA = `MMT_IDX_CTRL_A;
   localparam logic [15:0] RB = `MMT_IDX_CTRL_B;
   localparam logic [15:0] RC = `MMT_IDX_CAPTURE;
   logic [15:0] cmp_idx [3] = '{`MMT_IDX_CMP_ONE, `MMT_IDX_CMP_TWO, `MMT_IDX_CMP_THREE};
   logic [2:0]  codes [5] = '{`MMT_SEL_DIV8, `MMT_SEL_DIV16, `MMT_SEL_DIV32,
                              `MMT_SEL_DIV64, `MMT_SEL_DIV128};
   int          divs [5] = '{8, 16, 32, 64, 128};
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pos_req = 1'b0;
   logic        ovl_req = 1'b0;
   logic        pos_irq;
   logic        ovl_trip;
   logic        irq1;
   logic        irq2;
   logic        irq3;
   logic        dbg;
   logic [2:0]  prev = 3'b000;
   logic [31:0] seed = 32'hb737_3fd9;
   logic [31:0] rd;
   logic        err;
   logic [7:0]  bcfg = 8'h00;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          n1 = 0;
   int          n2 = 0;
   int          n3 = 0;
   int          nd = 0;
   int          s1;
   int          s2;
   int          s3;
   int          sd;

   mmt_timer_unit mmt_timer_unit_i (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .position_detect_irq(pos_irq), .overload_trip(ovl_trip),
      .irq_timer_one(irq1), .irq_timer_two(irq2), .irq_timer_three(irq3), .debug_pin(dbg));
   mmt_far_side mmt_far_side_i (.mclk(mclk), .pos_req(pos_req), .ovl_req(ovl_req),
      .position_detect_irq(pos_irq), .overload_trip(ovl_trip));

   always #5 mclk = ~mclk;

   //------------------------------------------------------------
   // checking and bus tasks
   //------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction

   // hold the request until pready is seen high at an edge
   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0000, idx, 2'b00};
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      check(what, rd, exp);
   endtask

   task automatic capchk(input logic [15:0] exp);
      apb(1'b1, RB, {24'h00_0000, bcfg | 8'h04});
      rdchk("capture", RC, {16'h0000, exp});
   endtask

   task automatic pulse(input logic pos);
      @(posedge mclk);
      if (pos) pos_req <= 1'b1;
      else ovl_req <= 1'b1;
      @(posedge mclk);
      pos_req <= 1'b0;
      ovl_req <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   // clear, run for three and a half ticks, stop: count holds 3
   task automatic run3(input logic [2:0] code, input int div);
      apb(1'b1, RA, {24'h00_0000, code, 5'b00100});
      apb(1'b1, RA, {24'h00_0000, code, 5'b00001});
      repeat (3 * div + div / 2 - 3) @(posedge mclk);
      apb(1'b1, RA, {24'h00_0000, code, 5'b00000});
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (irq1 === 1'b1) n1++;
      if (irq2 === 1'b1) n2++;
      if (irq3 === 1'b1) n3++;
      if (dbg === 1'b1) nd++;
      if (nrst) check("irq width", {29'h0, prev & {irq1, irq2, irq3}}, 0);
      prev <= {irq1, irq2, irq3};
      if (cycles == 30000) begin
         error_cnt++;
         end_of_test();
      end
   end

   //------------------------------------------------------------
   // scenarios
   //------------------------------------------------------------
   initial begin
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      rdchk("ctrl_a", RA, 0);
      rdchk("ctrl_b", RB, 0);
      rdchk("capture", RC, 0);
      for (int i = 0; i < 3; i++) rdchk("cmp", cmp_idx[i], 0);
      apb(1'b0, 16'h1fa7, 32'h0000_0000);
      check("unmapped err", {31'h0, err}, 1);
      check("unmapped data", rd, 0);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         apb(1'b1, cmp_idx[i % 3], {16'h0000, seed[15:0]});
         rdchk("cmp rw", cmp_idx[i % 3], {16'h0000, seed[15:0]});
      end
      for (int i = 0; i < 5; i++) begin
         run3(codes[i], divs[i]);
         capchk(16'h0003);
      end
      check("disarmed", 32'(n1 + n2 + n3), 0);
      run3(3'b011, 16);
      capchk(16'h0000);
      run3(`MMT_SEL_DIV8, 8);
      apb(1'b1, RC, 32'h0000_ffff);
      rdchk("capture ro", RC, 0);
      capchk(16'h0003);
      rdchk("ctrl_b cmd", RB, 0);
      apb(1'b1, RA, 32'h0000_0004);
      rdchk("ctrl_a cmd", RA, 0);
      rdchk("capture held", RC, 3);
      bcfg = 8'h02;
      apb(1'b1, RB, {24'h00_0000, bcfg});
      pulse(1'b1);
      rdchk("pos capture", RC, 0);
      run3(`MMT_SEL_DIV8, 8);
      bcfg = 8'h08;
      apb(1'b1, RB, {24'h00_0000, bcfg});
      pulse(1'b1);
      rdchk("pos capture off", RC, 0);
      pulse(1'b0);
      rdchk("ovl capture", RC, 3);
      apb(1'b1, RA, 32'h0000_0002);
      pulse(1'b0);
      capchk(16'h0003);
      pulse(1'b1);
      capchk(16'h0000);
      run3(`MMT_SEL_DIV8, 8);
      apb(1'b1, RA, 32'h0000_0008);
      pulse(1'b0);
      capchk(16'h0000);
      bcfg = 8'h80;
      apb(1'b1, RB, {24'h00_0000, bcfg});
      rdchk("ctrl_b dbg", RB, 32'h0000_0080);
      s1 = n1;
      s2 = n2;
      s3 = n3;
      sd = nd;
      apb(1'b1, RA, 32'h0000_0004);
      apb(1'b1, cmp_idx[1], 32'h0000_0005);
      apb(1'b1, RA, 32'h0000_0001);
      repeat (100) @(posedge mclk);
      check("eq fire", 32'(n2 - s2), 1);
      repeat (100) @(posedge mclk);
      check("eq once", 32'(n2 - s2), 1);
      apb(1'b1, cmp_idx[0], 32'h0000_0002);
      repeat (10) @(posedge mclk);
      check("mag fire", 32'(n1 - s1), 1);
      apb(1'b1, cmp_idx[1], 32'h0000_0002);
      repeat (10) @(posedge mclk);
      check("eq passed", 32'(n2 - s2), 1);
      apb(1'b1, cmp_idx[0], 32'h0000_0040);
      apb(1'b1, RA, 32'h0000_0000);
      apb(1'b1, RA, 32'h0000_0001);
      repeat (400) @(posedge mclk);
      check("stop disarms", 32'(n1 - s1), 1);
      apb(1'b1, cmp_idx[0], 32'h0000_0040);
      repeat (10) @(posedge mclk);
      check("rearm", 32'(n1 - s1), 2);
      apb(1'b1, RA, 32'h0000_0004);
      apb(1'b1, cmp_idx[2], 32'h0000_0006);
      apb(1'b1, RA, 32'h0000_0011);
      repeat (90) @(posedge mclk);
      apb(1'b1, RA, 32'h0000_0010);
      check("m3 fire", 32'(n3 - s3), 1);
      apb(1'b1, RB, {24'h00_0000, bcfg | 8'h04});
      apb(1'b0, RC, 32'h0000_0000);
      check("m3 clear", {31'h0, rd < 6}, 1);
      apb(1'b1, RA, 32'h0000_0011);
      repeat (150) @(posedge mclk);
      check("m3 once", 32'(n3 - s3), 1);
      apb(1'b1, RA, 32'h0000_0014);
      apb(1'b1, cmp_idx[2], 32'h0000_0006);
      apb(1'b1, RA, 32'h0000_0011);
      repeat (80) @(posedge mclk);
      check("m3 rearm", 32'(n3 - s3), 2);
      check("debug pin", 32'(nd - sd), 32'(n1 + n2 + n3 - s1 - s2 - s3));
      end_of_test();
   end
endmodule // mmt_timer_unit_tb_top
